// ---- common/gpm_pkg.sv ----
// package for the shared-pin gpio multiplexer: register map, field layouts, reset values
package gpm_pkg;
  // pin counts per port
  localparam int NUM_PINS = 25;
  localparam int PA_W = 8;
  localparam int PB_W = 8;
  localparam int PC_W = 8;
  localparam int PD_W = 1;
  // package variants
  typedef enum logic [1:0] {
    GPM_PKG8 = 2'b00,
    GPM_PKG20 = 2'b01,
    GPM_PKG28 = 2'b10
  } gpm_variant_t;
  // register indexes (word offsets on the plain port)
  localparam logic [7:0] REG_PORT_SEL = 8'h00;   // selects port 0..3 (A..D)
  localparam logic [7:0] REG_DIR = 8'h01;        // 1 = input
  localparam logic [7:0] REG_ALT_EN = 8'h02;
  localparam logic [7:0] REG_OPEN_DRAIN = 8'h03;
  localparam logic [7:0] REG_HIGH_DRIVE = 8'h04;
  localparam logic [7:0] REG_PULL_UP = 8'h05;
  localparam logic [7:0] REG_STOP_WAKE = 8'h06;
  localparam logic [7:0] REG_AFS_FIRST = 8'h07;
  localparam logic [7:0] REG_AFS_SECOND = 8'h08;
  localparam logic [7:0] REG_OUT_DATA = 8'h09;
  localparam logic [7:0] REG_IN_DATA = 8'h0A;
  localparam logic [7:0] REG_LED_EN = 8'h0B;
  localparam logic [7:0] REG_LED_LVL_H = 8'h0C;
  localparam logic [7:0] REG_LED_LVL_L = 8'h0D;
  localparam logic [7:0] REG_STATUS = 8'h0E;
  // status register fields
  localparam int ST_DBG_UNLOCK = 0;
  localparam int ST_XTAL = 1;
  // reset values
  localparam logic [7:0] RST_DIR = 8'hFF;        // all inputs
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_PD_ALT = 8'h01;     // port d bit 0 starts as reset pin
  // led sink current codes
  localparam logic [1:0] LED_3MA = 2'b00;
  localparam logic [1:0] LED_7MA = 2'b01;
  localparam logic [1:0] LED_13MA = 2'b10;
  localparam logic [1:0] LED_20MA = 2'b11;
  // per-pin control bundle
  typedef struct packed {
    logic dir_in;
    logic alt_en;
    logic open_drain;
    logic high_drive;
    logic pull_up;
    logic stop_wake;
    logic afs_first;
    logic afs_second;
    logic out_data;
  } gpm_pin_cfg_t;
  // per-pin drive result
  typedef struct packed {
    logic out;
    logic oe_n;
  } gpm_pin_drv_t;
endpackage : gpm_pkg

// ---- rtl/gpm_top.sv ----
// shared-pin gpio multiplexer with led sink, shared reset and debug pins
`timescale 1ns/100ps
module gpm_top (
  input wire logic clk,
  input wire logic nrst,
  input wire gpm_pkg::gpm_variant_t variant,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic [gpm_pkg::NUM_PINS-1:0] pin_in,
  output logic [gpm_pkg::NUM_PINS-1:0] pin_out,
  output logic [gpm_pkg::NUM_PINS-1:0] pin_oe_n,
  output logic [gpm_pkg::NUM_PINS-1:0] pin_pull_up,
  output logic [gpm_pkg::NUM_PINS-1:0] pin_high_drive,
  output logic [gpm_pkg::NUM_PINS-1:0] pin_stop_wake,
  output logic [gpm_pkg::NUM_PINS-1:0] pin_alt_sel,
  output logic [7:0] led_sink_on,
  output logic [15:0] led_level,
  input wire logic [gpm_pkg::NUM_PINS-1:0] periph_out,
  input wire logic [gpm_pkg::NUM_PINS-1:0] periph_oe_n,
  output logic [gpm_pkg::NUM_PINS-1:0] periph_in,
  input wire logic xtal_en,
  input wire logic timer0_out_mode,
  input wire logic timer1_out_mode,
  input wire logic dbg_unlock_seen,
  input wire logic sys_reset,
  output logic dbg_unlocked,
  output logic ext_reset_req
);
  ////////////////////////////////////////////////////////////////////////////
  // reset synchroniser and input synchroniser
  logic rst_meta;
  logic rst_n;
  logic [gpm_pkg::NUM_PINS-1:0] in_meta;
  logic [gpm_pkg::NUM_PINS-1:0] in_sync;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      in_meta <= '0;
      in_sync <= '0;
    end else begin
      in_meta <= pin_in;
      in_sync <= in_meta;
    end
  end
  // system reset active while either source is asserted
  logic in_reset;
  assign in_reset = !rst_n || sys_reset;

  ////////////////////////////////////////////////////////////////////////////
  // control registers, one byte per port per field
  logic [1:0] port_sel;
  logic [3:0][7:0] dir_r, alt_r, od_r, hd_r, pu_r, sw_r, alt_function_select_first_r, alt_function_select_second_r, out_r;
  logic [7:0] led_en_r, lvl_h_r, lvl_l_r;
  logic [7:0] valid_mask;
  logic [gpm_pkg::NUM_PINS-1:0] flat_in;
  logic [gpm_pkg::NUM_PINS-1:0] sync_rd;
  // valid pins of the selected port for this variant
  always_comb begin
    valid_mask = 8'h00;
    case (port_sel)
      2'd0: valid_mask = (variant == gpm_pkg::GPM_PKG8) ? 8'h3F : 8'hFF;
      2'd1: valid_mask = (variant == gpm_pkg::GPM_PKG8) ? 8'h00 :
                         (variant == gpm_pkg::GPM_PKG20) ? 8'h0F : 8'hFF;
      2'd2: valid_mask = (variant == gpm_pkg::GPM_PKG8) ? 8'h00 :
                         (variant == gpm_pkg::GPM_PKG20) ? 8'h0F : 8'hFF;
      2'd3: valid_mask = (variant == gpm_pkg::GPM_PKG8) ? 8'h00 : 8'h01;
      default: valid_mask = 8'h00;
    endcase
  end
  // port select register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      port_sel <= 2'd0;
    end else if (wr && addr == gpm_pkg::REG_PORT_SEL) begin
      port_sel <= wdata[1:0];
    end
  end
  // per-field writes only touch the addressed port's bits
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dir_r <= {4{gpm_pkg::RST_DIR}};
      od_r <= '0;
      hd_r <= '0;
      pu_r <= '0;
      sw_r <= '0;
      alt_function_select_first_r <= '0;
      alt_function_select_second_r <= '0;
      out_r <= '0;
    end else if (wr) begin
      case (addr)
        gpm_pkg::REG_DIR: dir_r[port_sel] <= wdata & valid_mask;
        gpm_pkg::REG_OPEN_DRAIN: od_r[port_sel] <= wdata & valid_mask;
        gpm_pkg::REG_HIGH_DRIVE: hd_r[port_sel] <= wdata & valid_mask;
        gpm_pkg::REG_PULL_UP: pu_r[port_sel] <= wdata & valid_mask;
        gpm_pkg::REG_STOP_WAKE: sw_r[port_sel] <= wdata & valid_mask;
        gpm_pkg::REG_AFS_FIRST: if (port_sel != 2'd0) alt_function_select_first_r[port_sel] <= wdata & valid_mask;
        gpm_pkg::REG_AFS_SECOND: if (port_sel >= 2'd2) alt_function_select_second_r[port_sel] <= wdata & valid_mask;
        gpm_pkg::REG_OUT_DATA: out_r[port_sel] <= wdata & valid_mask;
        default: ;
      endcase
    end
  end
  // alternate enable; shared reset pin reverts on any system reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      alt_r <= {gpm_pkg::RST_PD_ALT, gpm_pkg::RST_ZERO, gpm_pkg::RST_ZERO, gpm_pkg::RST_ZERO};
    end else if (in_reset) begin
      alt_r[3][0] <= 1'b1;
      alt_r[0][2] <= (variant == gpm_pkg::GPM_PKG8) ? 1'b1 : alt_r[0][2];
    end else if (wr && addr == gpm_pkg::REG_ALT_EN) begin
      alt_r[port_sel] <= wdata & valid_mask;
    end
  end
  // led control registers, port c only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      led_en_r <= gpm_pkg::RST_ZERO;
      lvl_h_r <= gpm_pkg::RST_ZERO;
      lvl_l_r <= gpm_pkg::RST_ZERO;
    end else if (wr) begin
      case (addr)
        gpm_pkg::REG_LED_EN: led_en_r <= wdata;
        gpm_pkg::REG_LED_LVL_H: lvl_h_r <= wdata;
        gpm_pkg::REG_LED_LVL_L: lvl_l_r <= wdata;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // debug pin unlock latch: sampled only while in reset
  logic dbg_lock_open;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dbg_lock_open <= 1'b0;
    end else if (in_reset) begin
      dbg_lock_open <= (variant == gpm_pkg::GPM_PKG8) && dbg_unlock_seen;
    end
  end
  assign dbg_unlocked = dbg_lock_open; // stays until next reset

  ////////////////////////////////////////////////////////////////////////////
  // per-pin multiplexing
  gpm_pkg::gpm_pin_drv_t [gpm_pkg::NUM_PINS-1:0] drv;
  gpm_pkg::gpm_pin_cfg_t [gpm_pkg::NUM_PINS-1:0] cfg;
  logic [gpm_pkg::NUM_PINS-1:0] led_mode;
  logic [gpm_pkg::NUM_PINS-1:0] pin_present;
  genvar g;
  generate
    for (g = 0; g < gpm_pkg::NUM_PINS; g++) begin : g_pin
      localparam int P = (g < 8) ? 0 : (g < 16) ? 1 : (g < 24) ? 2 : 3;
      localparam int B = g - 8 * P;
      assign cfg[g] = '{dir_in: dir_r[P][B], alt_en: alt_r[P][B], open_drain: od_r[P][B],
                        high_drive: hd_r[P][B], pull_up: pu_r[P][B], stop_wake: sw_r[P][B],
                        afs_first: alt_function_select_first_r[P][B], afs_second: alt_function_select_second_r[P][B], out_data: out_r[P][B]};
      // led mode only through the first alternate set bit on port c
      if (P == 2) begin : g_led
        assign led_mode[g] = cfg[g].alt_en && cfg[g].afs_first;
        assign led_sink_on[B] = led_mode[g] && led_en_r[B];
        assign led_level[2*B+1:2*B] = {lvl_h_r[B], lvl_l_r[B]};
      end else begin : g_noled
        assign led_mode[g] = 1'b0;
      end
      always_comb begin
        drv[g] = '{out: 1'b0, oe_n: 1'b1};
        if (!pin_present[g]) begin
          drv[g] = '{out: 1'b0, oe_n: 1'b1};
        end else if (xtal_en && P == 0 && B < 2) begin
          drv[g] = '{out: 1'b0, oe_n: 1'b1}; // oscillator owns the pin
        end else if (led_mode[g]) begin
          drv[g] = '{out: 1'b0, oe_n: !led_sink_on[B % 8]}; // sink only when enabled
        end else if (cfg[g].alt_en) begin
          drv[g] = '{out: periph_out[g], oe_n: periph_oe_n[g]};
          if (cfg[g].open_drain && periph_out[g]) drv[g].oe_n = 1'b1;
        end else if (!cfg[g].dir_in || (P == 3)) begin
          // port d bit 0 is output only open drain releases a one
          drv[g] = '{out: cfg[g].out_data, oe_n: cfg[g].open_drain && cfg[g].out_data};
        end
      end
    end
  endgenerate
  // pins existing in this variant
  always_comb begin
    pin_present = '0;
    case (variant)
      gpm_pkg::GPM_PKG8: pin_present[5:0] = 6'h3F;
      gpm_pkg::GPM_PKG20: pin_present = {1'b1, 8'h0F, 8'h0F, 8'hFF};
      gpm_pkg::GPM_PKG28: pin_present = {1'b1, 8'hFF, 8'hFF, 8'hFF};
      default: pin_present = '0;
    endcase
  end
  // debug pin leaves the port once unlocked; port d bit 0 feeds no input
  always_comb begin
    for (int i = 0; i < gpm_pkg::NUM_PINS; i++) begin
      pin_out[i] = drv[i].out;
      pin_oe_n[i] = drv[i].oe_n;
      pin_pull_up[i] = cfg[i].pull_up && pin_present[i];
      pin_high_drive[i] = cfg[i].high_drive;
      pin_stop_wake[i] = cfg[i].stop_wake;
      pin_alt_sel[i] = cfg[i].alt_en;
      flat_in[i] = in_sync[i] && pin_present[i];
    end
    if (dbg_lock_open) begin
      pin_oe_n[0] = 1'b1;
    end
    flat_in[24] = 1'b0; // no input path on port d bit 0
    if (dbg_lock_open) flat_in[0] = 1'b0;
  end
  assign periph_in = flat_in;
  assign sync_rd = flat_in;
  // shared reset pin held low asserts reset towards the system
  assign ext_reset_req = ((variant == gpm_pkg::GPM_PKG8) ? (alt_r[0][2] && !in_sync[2])
                                                         : (alt_r[3][0] && !in_sync[24]));

  ////////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the strobe
  logic [7:0] next_rdata;
  logic [31:0] in_pad;
  assign in_pad = {7'h00, sync_rd};
  always_comb begin
    next_rdata = 8'h00;
    case (addr)
      gpm_pkg::REG_PORT_SEL: next_rdata = {6'h00, port_sel};
      gpm_pkg::REG_DIR: next_rdata = dir_r[port_sel];
      gpm_pkg::REG_ALT_EN: next_rdata = alt_r[port_sel];
      gpm_pkg::REG_OPEN_DRAIN: next_rdata = od_r[port_sel];
      gpm_pkg::REG_HIGH_DRIVE: next_rdata = hd_r[port_sel];
      gpm_pkg::REG_PULL_UP: next_rdata = pu_r[port_sel];
      gpm_pkg::REG_STOP_WAKE: next_rdata = sw_r[port_sel];
      gpm_pkg::REG_AFS_FIRST: next_rdata = alt_function_select_first_r[port_sel];
      gpm_pkg::REG_AFS_SECOND: next_rdata = alt_function_select_second_r[port_sel];
      gpm_pkg::REG_OUT_DATA: next_rdata = out_r[port_sel];
      gpm_pkg::REG_IN_DATA: next_rdata = in_pad[8*port_sel +: 8] & valid_mask;
      gpm_pkg::REG_LED_EN: next_rdata = led_en_r;
      gpm_pkg::REG_LED_LVL_H: next_rdata = lvl_h_r;
      gpm_pkg::REG_LED_LVL_L: next_rdata = lvl_l_r;
      gpm_pkg::REG_STATUS: next_rdata = {6'h00, xtal_en, dbg_lock_open};
      default: next_rdata = 8'h00;
    endcase
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  a_xtal_override: assert property (@(posedge clk) disable iff (!rst_n)
    xtal_en |-> pin_oe_n[0] && pin_oe_n[1]) else $error("crystal pins driven");
  a_pd0_no_input: assert property (@(posedge clk) disable iff (!rst_n)
    periph_in[24] == 1'b0) else $error("port d bit 0 input seen");
  a_reset_reverts: assert property (@(posedge clk) disable iff (!nrst)
    sys_reset |=> alt_r[3][0]) else $error("reset pin not restored");
  a_open_drain_one: assert property (@(posedge clk) disable iff (!rst_n)
    (!pin_oe_n[8] && od_r[1][0]) |-> !pin_out[8]) else $error("open drain drove high");
  a_led_gated: assert property (@(posedge clk) disable iff (!rst_n)
    led_sink_on[0] |-> alt_r[2][0] && alt_function_select_first_r[2][0] && led_en_r[0]) else $error("led without select");
  a_led_level: assert property (@(posedge clk) disable iff (!rst_n)
    led_level[1:0] == {lvl_h_r[0], lvl_l_r[0]}) else $error("led level code wrong");
  a_port_drive: assert property (@(posedge clk) disable iff (!rst_n)
    (pin_present[3] && !xtal_en && !alt_r[0][3] && !dir_r[0][3] && !od_r[0][3]) |->
    !pin_oe_n[3] && pin_out[3] == out_r[0][3]) else $error("port data not driven");
  a_alt_dir: assert property (@(posedge clk) disable iff (!rst_n)
    (pin_present[4] && alt_r[0][4] && !od_r[0][4]) |-> pin_oe_n[4] == periph_oe_n[4])
    else $error("peripheral direction ignored");
  a_dbg_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !in_reset |=> $stable(dbg_lock_open)) else $error("debug lock changed outside reset");

  ////////////////////////////////////////////////////////////////////////////
  // further checks on pin ownership and register gating
  // two cycles of system reset: the shared reset pin is back in reset function
  sequence s_reset_held;
    sys_reset ##1 sys_reset;
  endsequence
  a_reset_held_pin: assert property (@(posedge clk) disable iff (!rst_n)
    s_reset_held |-> alt_r[3][0] && pin_alt_sel[24])
    else $error("reset pin not held in reset function");
  // port d bit 0 as port pin without open drain always drives its stored data
  a_pd0_out_only: assert property (@(posedge clk) disable iff (!rst_n)
    (pin_present[24] && !alt_r[3][0] && !od_r[3][0]) |-> !pin_oe_n[24] && pin_out[24] == out_r[3][0])
    else $error("port d bit 0 not driving");
  // unlocked debug pin is neither driven nor seen by the port
  a_dbg_pin_off: assert property (@(posedge clk) disable iff (!rst_n)
    dbg_lock_open |-> pin_oe_n[0] && !periph_in[0])
    else $error("debug pin still on the port");
  // debug unlock only exists on the 8-pin part
  a_dbg_only_small: assert property (@(posedge clk) disable iff (!rst_n)
    (in_reset && variant != gpm_pkg::GPM_PKG8) |=> !dbg_lock_open)
    else $error("debug unlocked on large part");
  // a missing pin is released with no pull-up
  a_absent_released: assert property (@(posedge clk) disable iff (!rst_n)
    !pin_present[8] |-> pin_oe_n[8] && !pin_pull_up[8])
    else $error("absent pin active");
  // led mode without its enable leaves the pin released
  a_sink_release: assert property (@(posedge clk) disable iff (!rst_n)
    (led_mode[16] && !led_en_r[0]) |-> pin_oe_n[16])
    else $error("led pin sinks while disabled");
  // enabled led sink pulls the pin low
  a_sink_drive: assert property (@(posedge clk) disable iff (!rst_n)
    (pin_present[16] && led_sink_on[0]) |-> !pin_oe_n[16] && !pin_out[16])
    else $error("led sink not driving low");
  // port a keeps no alternate set selection
  a_afs_port_a: assert property (@(posedge clk) disable iff (!rst_n)
    alt_function_select_first_r[0] == 8'h00)
    else $error("port a alternate set written");
  // port b second selection stays unused
  a_alt_function_select_second_port_b: assert property (@(posedge clk) disable iff (!rst_n)
    alt_function_select_second_r[1] == 8'h00)
    else $error("port b second select written");
  // open drain also applies to a peripheral output one
  a_alt_open_drain: assert property (@(posedge clk) disable iff (!rst_n)
    (pin_present[9] && alt_r[1][1] && od_r[1][1] && periph_out[9]) |-> pin_oe_n[9])
    else $error("open drain peripheral drove high");
  // any reset on the 8-pin part returns port a bit 2 to reset function
  a_reset_pin_small: assert property (@(posedge clk) disable iff (!rst_n)
    (variant == gpm_pkg::GPM_PKG8 && in_reset) |=> alt_r[0][2])
    else $error("port a bit 2 not in reset function");
  // no reset request once the pin left its reset function
  a_ext_req_idle: assert property (@(posedge clk) disable iff (!rst_n)
    (variant != gpm_pkg::GPM_PKG8 && !alt_r[3][0]) |-> !ext_reset_req)
    else $error("reset request from port pin");
  // input direction leaves the pin released, except on output-only port d bit 0
  a_dir_input: assert property (@(posedge clk) disable iff (!rst_n)
    (pin_present[5] && !alt_r[0][5] && dir_r[0][5]) |-> pin_oe_n[5])
    else $error("input pin driven");
  // drive strength follows its register bit
  a_high_drive: assert property (@(posedge clk) disable iff (!rst_n)
    pin_high_drive[3] == hd_r[0][3])
    else $error("drive strength mismatch");
  // stop wake follows its register bit on another port
  a_stop_wake: assert property (@(posedge clk) disable iff (!rst_n)
    pin_stop_wake[10] == sw_r[1][2])
    else $error("stop wake mismatch");
  // alternate select output follows the alternate register
  a_alt_select: assert property (@(posedge clk) disable iff (!rst_n)
    pin_alt_sel[11] == alt_r[1][3])
    else $error("alternate select mismatch");
endmodule : gpm_top

// ---- tb/gpm_board_model.sv ----
// board-side model: resolves every pad from device drive, board drive and pull-ups
`timescale 1ns/100ps
module gpm_board_model (
  input wire logic clk,
  input wire logic [gpm_pkg::NUM_PINS-1:0] pin_out,
  input wire logic [gpm_pkg::NUM_PINS-1:0] pin_oe_n,
  input wire logic [gpm_pkg::NUM_PINS-1:0] pin_pull_up,
  input wire logic [gpm_pkg::NUM_PINS-1:0] ext_en,
  input wire logic [gpm_pkg::NUM_PINS-1:0] ext_val,
  output logic [gpm_pkg::NUM_PINS-1:0] pin_in
);
  ////////////////////////////////////////
  logic [gpm_pkg::NUM_PINS-1:0] wander = '0;
  // a pad nobody drives keeps changing, so a stale level is never trusted
  always @(posedge clk) begin
    wander <= ~wander;
  end
  // device drive first, then the board, then the pull-up, else the wandering level
  always_comb begin
    for (int i = 0; i < gpm_pkg::NUM_PINS; i++) begin
      if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (pin_pull_up[i]) pin_in[i] = 1'b1;
      else pin_in[i] = wander[i];
    end
  end
endmodule : gpm_board_model

// ---- tb/gpm_top_tb_top.sv ----
// self-checking bench for the shared-pin gpio multiplexer
`timescale 1ns/100ps
module gpm_top_tb_top;
  localparam int N = gpm_pkg::NUM_PINS;
  logic clk = 1'b0;
  logic nrst;
  gpm_pkg::gpm_variant_t variant;
  logic [7:0] addr, wdata, rdata, led_sink_on;
  logic [15:0] led_level;
  logic wr, rd, xtal_en, tm0, tm1, dbg_seen, sys_reset, dbg_unlocked, ext_reset_req;
  logic [N-1:0] pin_in, pin_out, pin_oe_n, pin_pull_up, pin_high_drive, pin_stop_wake, pin_alt_sel;
  logic [N-1:0] periph_out, periph_oe_n, periph_in, ext_en, ext_val;
  int n_mismatch = 0;
  int n_compared = 0;
  // 200 MHz system clock
  always #2.5 clk = ~clk;
  gpm_top u_dut (
    .clk(clk), .nrst(nrst), .variant(variant), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pull_up(pin_pull_up),
    .pin_high_drive(pin_high_drive), .pin_stop_wake(pin_stop_wake), .pin_alt_sel(pin_alt_sel),
    .led_sink_on(led_sink_on), .led_level(led_level), .periph_out(periph_out), .periph_oe_n(periph_oe_n),
    .periph_in(periph_in), .xtal_en(xtal_en), .timer0_out_mode(tm0), .timer1_out_mode(tm1),
    .dbg_unlock_seen(dbg_seen), .sys_reset(sys_reset), .dbg_unlocked(dbg_unlocked), .ext_reset_req(ext_reset_req)
  );
  gpm_board_model u_board (
    .clk(clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pull_up(pin_pull_up),
    .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in)
  );
  ////////////////////////////////////////
  // compare helpers, one per kind of result
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t register read %h expected %h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_pin(input logic [N-1:0] got, input logic [N-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t pin state %h expected %h", $time, got, exp);
    end
  endtask : chk_pin
  // one-cycle write strobe, then settle
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  // one-cycle read strobe, data taken in the following cycle
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk_reg(rdata & m, exp);
  endtask : rd_chk
  // reset for two cycles with the debug sequence shown or not
  task automatic do_reset(input gpm_pkg::gpm_variant_t v, input logic seen);
    @(posedge clk);
    nrst <= 1'b0;
    variant <= v;
    dbg_seen <= seen;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    dbg_seen <= 1'b0;
    #1;
  endtask : do_reset
  task automatic summarize();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize
  ////////////////////////////////////////
  // watchdog cuts a hang short
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    summarize();
  end
  // main test sequence
  initial begin
    {nrst, wr, rd, xtal_en, tm0, tm1, dbg_seen, sys_reset} = '0;
    variant = gpm_pkg::GPM_PKG28;
    {addr, wdata} = '0;
    {periph_out, ext_en, ext_val} = '0;
    periph_oe_n = '1;
    do_reset(gpm_pkg::GPM_PKG28, 1'b0);
    chk_pin(pin_oe_n, '1);
    chk_pin(pin_alt_sel, 25'h100_0000);
    rd_chk(gpm_pkg::REG_DIR, 8'hFF, gpm_pkg::RST_DIR);
    // port b config levels and select bits
    wr_reg(gpm_pkg::REG_PORT_SEL, 8'h01);
    wr_reg(gpm_pkg::REG_PULL_UP, 8'h0F);
    wr_reg(gpm_pkg::REG_HIGH_DRIVE, 8'h30);
    wr_reg(gpm_pkg::REG_STOP_WAKE, 8'h3C);
    chk_pin({9'h0, pin_pull_up[15:0]}, 25'h0F00);
    chk_pin({9'h0, pin_high_drive[15:0]}, 25'h3000);
    chk_pin({9'h0, pin_stop_wake[15:0]}, 25'h3C00);
    wr_reg(gpm_pkg::REG_AFS_FIRST, 8'h15);
    wr_reg(gpm_pkg::REG_AFS_SECOND, 8'h3F);
    rd_chk(gpm_pkg::REG_AFS_FIRST, 8'hFF, 8'h15);
    rd_chk(gpm_pkg::REG_AFS_SECOND, 8'hFF, 8'h00);
    // port a output data, input readback, open drain
    wr_reg(gpm_pkg::REG_PORT_SEL, 8'h00);
    wr_reg(gpm_pkg::REG_OUT_DATA, 8'hA5);
    wr_reg(gpm_pkg::REG_DIR, 8'h0F);
    chk_pin({9'h0, pin_oe_n[7:0], pin_out[7:4], 4'h0}, {9'h0, 8'h0F, 4'hA, 4'h0});
    ext_en <= 25'h0F;
    ext_val <= 25'h06;
    repeat (4) @(posedge clk);
    rd_chk(gpm_pkg::REG_IN_DATA, 8'hFF, 8'hA6);
    wr_reg(gpm_pkg::REG_OPEN_DRAIN, 8'hF0);
    chk_pin({19'h0, pin_oe_n[7:4], pin_out[6], pin_out[4]}, 25'b101000);
    wr_reg(gpm_pkg::REG_OPEN_DRAIN, 8'h00);
    ext_en <= '0;
    // crystal takes bits 0 and 1 away from the port
    wr_reg(gpm_pkg::REG_DIR, 8'h0C);
    chk_pin({21'h0, pin_oe_n[1:0], pin_out[1:0]}, 25'b0001);
    xtal_en <= 1'b1;
    @(posedge clk);
    #1 chk_pin({23'h0, pin_oe_n[1:0]}, 25'b11);
    rd_chk(gpm_pkg::REG_STATUS, 8'h02, 8'h02);
    xtal_en <= 1'b0;
    // peripheral owns direction on alternate pins, timer pins alike
    periph_out[3] <= 1'b1;
    periph_oe_n[3] <= 1'b0;
    periph_oe_n[6] <= 1'b0;
    tm0 <= 1'b1;
    tm1 <= 1'b1;
    wr_reg(gpm_pkg::REG_ALT_EN, 8'h48);
    chk_pin({22'h0, pin_alt_sel[3], pin_oe_n[3], pin_out[3]}, 25'b101);
    chk_pin({22'h0, pin_alt_sel[6], pin_oe_n[6], pin_out[6]}, 25'b100);
    periph_oe_n[3] <= 1'b1;
    @(posedge clk);
    #1 chk_pin({24'h0, pin_oe_n[3]}, 25'b1);
    // port c led sink with all four levels
    wr_reg(gpm_pkg::REG_PORT_SEL, 8'h02);
    wr_reg(gpm_pkg::REG_ALT_EN, 8'hFF);
    wr_reg(gpm_pkg::REG_AFS_FIRST, 8'h0F);
    wr_reg(gpm_pkg::REG_LED_EN, 8'h0F);
    wr_reg(gpm_pkg::REG_LED_LVL_H, 8'h0C);
    wr_reg(gpm_pkg::REG_LED_LVL_L, 8'h0A);
    chk_pin({17'h0, led_sink_on}, 25'h0F);
    chk_pin({9'h0, led_level}, 25'h00E4);
    wr_reg(gpm_pkg::REG_AFS_FIRST, 8'h0E);
    chk_pin({17'h0, led_sink_on}, 25'h0E);
    // shared reset pin on port d
    wr_reg(gpm_pkg::REG_PORT_SEL, 8'h03);
    rd_chk(gpm_pkg::REG_ALT_EN, 8'h01, 8'h01);
    ext_en <= 25'h100_0000;
    repeat (4) @(posedge clk);
    #1 chk_pin({24'h0, ext_reset_req}, 25'b1);
    ext_en <= '0;
    wr_reg(gpm_pkg::REG_ALT_EN, 8'h00);
    wr_reg(gpm_pkg::REG_DIR, 8'h00);
    wr_reg(gpm_pkg::REG_OUT_DATA, 8'h01);
    chk_pin({22'h0, pin_alt_sel[24], pin_oe_n[24], pin_out[24]}, 25'b001);
    chk_pin({24'h0, periph_in[24]}, 25'b0);
    sys_reset <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk_pin({24'h0, pin_alt_sel[24]}, 25'b1);
    sys_reset <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk_pin({24'h0, pin_alt_sel[24]}, 25'b1);
    // 8-pin part, debug unlocked during reset; board stays off the reset pin
    do_reset(gpm_pkg::GPM_PKG8, 1'b1);
    chk_pin({24'h0, dbg_unlocked}, 25'b1);
    rd_chk(gpm_pkg::REG_STATUS, 8'h01, 8'h01);
    ext_en <= 25'h01;
    ext_val <= 25'h05;
    repeat (4) @(posedge clk);
    #1 chk_pin({24'h0, periph_in[0]}, 25'b0);
    ext_en <= '0;
    wr_reg(gpm_pkg::REG_ALT_EN, 8'h00);
    wr_reg(gpm_pkg::REG_DIR, 8'h00);
    chk_pin({19'h0, pin_oe_n[7:2]}, 25'b110000);
    wr_reg(gpm_pkg::REG_PORT_SEL, 8'h01);
    wr_reg(gpm_pkg::REG_DIR, 8'h00);
    chk_pin({17'h0, pin_oe_n[15:8]}, 25'hFF);
    // 8-pin part without the sequence: debug stays off, pins are inputs
    do_reset(gpm_pkg::GPM_PKG8, 1'b0);
    chk_pin({23'h0, dbg_unlocked, pin_oe_n[0]}, 25'b01);
    ext_en <= 25'h05;
    repeat (4) @(posedge clk);
    rd_chk(gpm_pkg::REG_IN_DATA, 8'h05, 8'h05);
    summarize();
  end
endmodule : gpm_top_tb_top
